/* File: hw/nbc_host.sv */
// nbc_host: nand bus host sequencer with write data fifo
// assumes nbc_pkg compiled first; pins reach a nand device through pads
`timescale 1ns/100ps
`default_nettype none

module nbc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // nbc_fifo

module nbc_host #(
  parameter int unsigned BUS_W = 8,
  parameter int unsigned LEN_W = 12,
  parameter int unsigned FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       rst_n_i,
  // operation request
  input  wire logic                       cmd_valid_i,
  output logic                            cmd_ready_o,
  input  wire logic [3:0]                 cmd_op_i,
  input  wire logic [nbc_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [LEN_W-1:0]           cmd_len_i,
  output logic                            done_o,
  output logic                            busy_o,
  output logic                            dev_ready_o,
  // write data in
  input  wire logic                       wr_valid_i,
  output logic                            wr_ready_o,
  input  wire logic [BUS_W-1:0]           wr_data_i,
  // read data out
  output logic                            rd_valid_o,
  output logic      [BUS_W-1:0]           rd_data_o,
  // nand pins
  output logic                            nand_ce_n_o,
  output logic                            nand_cle_o,
  output logic                            nand_ale_o,
  output logic                            nand_we_n_o,
  output logic                            read_strobe_n_o,
  output logic                            nand_wp_n_o,
  output logic      [BUS_W-1:0]           io_bus_o,
  output logic                            io_bus_oe_o,
  input  wire logic [BUS_W-1:0]           io_bus_i,
  input  wire logic                       ready_busy_n_i
);
  localparam logic [nbc_pkg::TMR_W-1:0] T_SETUP = nbc_pkg::TMR_W'(nbc_pkg::SETUP_CYC - 1);
  localparam logic [nbc_pkg::TMR_W-1:0] T_WLOW  = nbc_pkg::TMR_W'(nbc_pkg::WLOW_CYC - 1);
  localparam logic [nbc_pkg::TMR_W-1:0] T_RLOW  = nbc_pkg::TMR_W'(nbc_pkg::RLOW_CYC - 1);
  localparam logic [nbc_pkg::TMR_W-1:0] T_HIGH  = nbc_pkg::TMR_W'(nbc_pkg::HIGH_CYC - 1);
  localparam logic [nbc_pkg::TMR_W-1:0] T_BUSY  = nbc_pkg::TMR_W'(nbc_pkg::BUSY_CYC - 1);

  // address byte for cycle idx; x16 columns are one bit narrower
  function automatic logic [7:0] addr_byte(input logic [1:0] idx,
                                           input logic [nbc_pkg::ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (BUS_W == 16) begin
      // x16 cycle layout, column 0-10, page 11-16, block 17-26
      case (idx)
        2'h0:    b = a[7:0];
        2'h1:    b = {5'h00, a[10:8]};
        2'h2:    b = a[18:11];
        default: b = a[26:19];
      endcase
    end else begin
      // x8 cycle layout, column 0-11, page 12-17, block 18-27
      case (idx)
        2'h0:    b = a[7:0];
        2'h1:    b = {4'h0, a[11:8]};
        2'h2:    b = a[19:12];
        default: b = a[27:20];
      endcase
    end
    return b;
  endfunction

  nbc_pkg::nbc_state_e        st_q;
  nbc_pkg::nbc_phase_e        ph_q;
  logic [nbc_pkg::TMR_W-1:0]  tmr_q;
  logic [7:0]                 c1_q;
  logic [7:0]                 c2_q;
  logic                       has_addr_q;
  logic                       has_c2_q;
  logic                       wdir_q;
  logic                       rdir_q;
  logic                       wait_q;
  logic                       modify_q;
  logic [1:0]                 acyc_q;
  logic [1:0]                 alast_q;
  logic [nbc_pkg::ADDR_W-1:0] addr_q;
  logic [LEN_W-1:0]           len_q;
  logic [BUS_W-1:0]           io_s1_q;
  logic [BUS_W-1:0]           io_s2_q;
  logic                       rb_s1_q;
  logic                       rb_s2_q;
  logic                       fifo_valid;
  logic                       fifo_pop;
  logic [BUS_W-1:0]           fifo_data;
  logic                       bus_st;
  logic                       cyc_done;
  logic                       accept;
  logic                       op_busy_ok;
  logic                       is_read;
  nbc_pkg::nbc_state_e        after_addr;
  nbc_pkg::nbc_state_e        after_c2;

  nbc_fifo #(
    .WIDTH (BUS_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wr_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // pin synchronisers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      io_s1_q <= '0;
      io_s2_q <= '0;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      io_s1_q <= io_bus_i;
      io_s2_q <= io_s1_q;
      rb_s1_q <= ready_busy_n_i;
      rb_s2_q <= rb_s1_q;
    end
  end

  assign dev_ready_o = rb_s2_q;
  assign busy_o      = (st_q != nbc_pkg::ST_IDLE);
  // only reset or status while device busy
  assign op_busy_ok  = (cmd_op_i == nbc_pkg::OP_RESET) || (cmd_op_i == nbc_pkg::OP_STATUS);
  assign cmd_ready_o = (st_q == nbc_pkg::ST_IDLE) && (rb_s2_q || op_busy_ok);
  assign accept      = cmd_valid_i & cmd_ready_o;

  assign bus_st   = (st_q == nbc_pkg::ST_CMD1) || (st_q == nbc_pkg::ST_ADDR) ||
                    (st_q == nbc_pkg::ST_WDATA) || (st_q == nbc_pkg::ST_CMD2) ||
                    (st_q == nbc_pkg::ST_RDATA);
  assign is_read  = (st_q == nbc_pkg::ST_RDATA);
  assign cyc_done = bus_st && (ph_q == nbc_pkg::PH_HIGH) && (tmr_q == '0);
  assign fifo_pop = cyc_done && (st_q == nbc_pkg::ST_WDATA);

  always_comb begin
    after_c2 = nbc_pkg::ST_DONE;
    if (wait_q) begin
      after_c2 = nbc_pkg::ST_WAITB;
    end else if (rdir_q && (len_q != '0)) begin
      after_c2 = nbc_pkg::ST_RDATA;
    end
    after_addr = after_c2;
    if (wdir_q && (len_q != '0)) begin
      after_addr = nbc_pkg::ST_WDATA;
    end else if (has_c2_q) begin
      after_addr = nbc_pkg::ST_CMD2;
    end
  end

  // operation decode at accept
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      c1_q       <= 8'h00;
      c2_q       <= 8'h00;
      has_addr_q <= 1'b0;
      has_c2_q   <= 1'b0;
      wdir_q     <= 1'b0;
      rdir_q     <= 1'b0;
      wait_q     <= 1'b0;
      modify_q   <= 1'b0;
      alast_q    <= nbc_pkg::ACYC_LAST;
      addr_q     <= '0;
    end else if (accept) begin
      addr_q     <= cmd_addr_i;
      has_addr_q <= 1'b1;
      has_c2_q   <= 1'b1;
      wdir_q     <= 1'b0;
      rdir_q     <= 1'b1;
      wait_q     <= 1'b1;
      modify_q   <= 1'b0;
      alast_q    <= nbc_pkg::ACYC_LAST;
      c1_q       <= nbc_pkg::C_READ;
      c2_q       <= nbc_pkg::C_READ_GO;
      case (cmd_op_i)
        // read, copy-back read, id, reset, program, cache program, erase
        nbc_pkg::OP_READ: begin
        end
        nbc_pkg::OP_READ_CB: begin
          c2_q   <= nbc_pkg::C_READ_CB;
          rdir_q <= 1'b0;
        end
        nbc_pkg::OP_READ_ID: begin
          c1_q     <= nbc_pkg::C_READ_ID;
          has_c2_q <= 1'b0;
          wait_q   <= 1'b0;
          alast_q  <= nbc_pkg::ACYC_FIRST;
        end
        nbc_pkg::OP_RESET: begin
          c1_q       <= nbc_pkg::C_RESET;
          has_addr_q <= 1'b0;
          has_c2_q   <= 1'b0;
          rdir_q     <= 1'b0;
        end
        nbc_pkg::OP_PROG: begin
          c1_q     <= nbc_pkg::C_PROG;
          c2_q     <= nbc_pkg::C_PROG_GO;
          wdir_q   <= 1'b1;
          rdir_q   <= 1'b0;
          modify_q <= 1'b1;
        end
        nbc_pkg::OP_CACHE_PROG: begin
          c1_q     <= nbc_pkg::C_PROG;
          c2_q     <= nbc_pkg::C_CPROG_GO;
          wdir_q   <= 1'b1;
          rdir_q   <= 1'b0;
          modify_q <= 1'b1;
        end
        nbc_pkg::OP_ERASE: begin
          c1_q     <= nbc_pkg::C_ERASE;
          c2_q     <= nbc_pkg::C_ERASE_GO;
          rdir_q   <= 1'b0;
          modify_q <= 1'b1;
        end
        // status is a single code then read
        nbc_pkg::OP_STATUS: begin
          c1_q       <= nbc_pkg::C_STATUS;
          has_addr_q <= 1'b0;
          has_c2_q   <= 1'b0;
          wait_q     <= 1'b0;
        end
        nbc_pkg::OP_CACHE_SEQ: begin
          c1_q       <= nbc_pkg::C_CACHE_SEQ;
          has_addr_q <= 1'b0;
          has_c2_q   <= 1'b0;
        end
        nbc_pkg::OP_CACHE_END: begin
          c1_q       <= nbc_pkg::C_CACHE_END;
          has_addr_q <= 1'b0;
          has_c2_q   <= 1'b0;
        end
        // random cache read 00h, address, 31h
        nbc_pkg::OP_CACHE_RAND: begin
          c2_q <= nbc_pkg::C_CACHE_SEQ;
        end
        default: begin
        end
      endcase
    end
  end

  // sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q   <= nbc_pkg::ST_IDLE;
      ph_q   <= nbc_pkg::PH_SETUP;
      tmr_q  <= '0;
      acyc_q <= nbc_pkg::ACYC_FIRST;
      len_q  <= '0;
    end else begin
      if (bus_st) begin
        if (tmr_q != '0) begin
          tmr_q <= tmr_q - 1'b1;
        end else begin
          case (ph_q)
            nbc_pkg::PH_SETUP: begin
              // write data stalls until the fifo holds a word
              if (st_q != nbc_pkg::ST_WDATA || fifo_valid) begin
                ph_q  <= nbc_pkg::PH_LOW;
                tmr_q <= is_read ? T_RLOW : T_WLOW;
              end
            end
            nbc_pkg::PH_LOW: begin
              ph_q  <= nbc_pkg::PH_HIGH;
              tmr_q <= T_HIGH;
            end
            default: begin
              ph_q  <= nbc_pkg::PH_SETUP;
              tmr_q <= T_SETUP;
            end
          endcase
        end
      end else if (tmr_q != '0) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (st_q)
        nbc_pkg::ST_IDLE: begin
          if (accept) begin
            // unknown ops are dropped without a bus cycle
            st_q  <= (cmd_op_i > nbc_pkg::OP_CACHE_RAND) ? nbc_pkg::ST_DONE : nbc_pkg::ST_CMD1;
            ph_q  <= nbc_pkg::PH_SETUP;
            tmr_q <= T_SETUP;
            len_q <= cmd_len_i;
          end
        end
        nbc_pkg::ST_CMD1: begin
          if (cyc_done) begin
            st_q   <= has_addr_q ? nbc_pkg::ST_ADDR : after_addr;
            acyc_q <= (c1_q == nbc_pkg::C_ERASE) ? nbc_pkg::ACYC_ROW : nbc_pkg::ACYC_FIRST;
            // single-code waits must not see ready before busy shows
            if (!has_addr_q && (after_addr == nbc_pkg::ST_WAITB)) begin
              tmr_q <= T_BUSY;
            end
          end
        end
        nbc_pkg::ST_ADDR: begin
          if (cyc_done) begin
            acyc_q <= acyc_q + 1'b1;
            if (acyc_q == alast_q) begin
              st_q <= after_addr;
            end
          end
        end
        nbc_pkg::ST_WDATA: begin
          if (cyc_done) begin
            len_q <= len_q - 1'b1;
            if (len_q == LEN_W'(1)) begin
              st_q <= nbc_pkg::ST_CMD2;
            end
          end
        end
        nbc_pkg::ST_CMD2: begin
          if (cyc_done) begin
            st_q  <= after_c2;
            tmr_q <= T_BUSY;
          end
        end
        nbc_pkg::ST_WAITB: begin
          if (tmr_q == '0) begin
            st_q <= nbc_pkg::ST_WAITR;
          end
        end
        nbc_pkg::ST_WAITR: begin
          if (rb_s2_q) begin
            st_q  <= (rdir_q && (len_q != '0)) ? nbc_pkg::ST_RDATA : nbc_pkg::ST_DONE;
            ph_q  <= nbc_pkg::PH_SETUP;
            tmr_q <= T_SETUP;
          end
        end
        nbc_pkg::ST_RDATA: begin
          if (cyc_done) begin
            len_q <= len_q - 1'b1;
            if (len_q == LEN_W'(1)) begin
              st_q <= nbc_pkg::ST_DONE;
            end
          end
        end
        nbc_pkg::ST_DONE: begin
          st_q <= nbc_pkg::ST_IDLE;
        end
        default: begin
          st_q <= nbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // read capture at the end of the low phase
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
      done_o     <= 1'b0;
    end else begin
      // one word per read strobe fall
      rd_valid_o <= is_read && (ph_q == nbc_pkg::PH_LOW) && (tmr_q == '0);
      if (is_read && (ph_q == nbc_pkg::PH_LOW) && (tmr_q == '0)) begin
        rd_data_o <= io_s2_q;
      end
      done_o <= (st_q == nbc_pkg::ST_DONE);
    end
  end

  // registered pins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      nand_ce_n_o     <= 1'b1;
      nand_cle_o      <= 1'b0;
      nand_ale_o      <= 1'b0;
      nand_we_n_o     <= 1'b1;
      read_strobe_n_o <= 1'b1;
      nand_wp_n_o     <= 1'b0;
      io_bus_o        <= '0;
      io_bus_oe_o     <= 1'b0;
    end else begin
      nand_ce_n_o <= (st_q == nbc_pkg::ST_IDLE) || (st_q == nbc_pkg::ST_DONE);
      nand_cle_o  <= (st_q == nbc_pkg::ST_CMD1) || (st_q == nbc_pkg::ST_CMD2);
      nand_ale_o  <= (st_q == nbc_pkg::ST_ADDR);
      // write strobe rises with bus held, read strobe high
      nand_we_n_o <= !(bus_st && !is_read && (ph_q == nbc_pkg::PH_LOW));
      // latches low, write strobe high, read strobe falls
      read_strobe_n_o <= !(is_read && (ph_q == nbc_pkg::PH_LOW));
      // unprotect only through program or erase
      nand_wp_n_o <= modify_q && (st_q != nbc_pkg::ST_IDLE);
      io_bus_oe_o <= bus_st && !is_read;
      case (st_q)
        // codes on the low eight lines
        nbc_pkg::ST_CMD1:  io_bus_o <= BUS_W'(c1_q);
        nbc_pkg::ST_CMD2:  io_bus_o <= BUS_W'(c2_q);
        nbc_pkg::ST_ADDR:  io_bus_o <= BUS_W'(addr_byte(acyc_q, addr_q));
        nbc_pkg::ST_WDATA: io_bus_o <= fifo_data;
        default:           io_bus_o <= '0;
      endcase
    end
  end
endmodule // nbc_host

`default_nettype wire

/* File: hw/nbc_pkg.sv */
// nbc_pkg: constants, op codes, command codes and timing for the nand bus controller
// assumes a 100 MHz controller clock and one nand device on the bus
package nbc_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // bus timing in ns, and read synchroniser stages
  localparam int unsigned SETUP_NS      = 20;
  localparam int unsigned STROBE_LOW_NS = 25;
  localparam int unsigned STROBE_HI_NS  = 20;
  localparam int unsigned READ_ACC_NS   = 30;
  localparam int unsigned BUSY_WAIT_NS  = 100;
  localparam int unsigned SYNC_STAGES   = 3;

  // least times round up to whole cycles
  localparam int unsigned SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WLOW_CYC    = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HIGH_CYC    = (STROBE_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RLOW_CYC    = (READ_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
  localparam int unsigned BUSY_CYC    = (BUSY_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W       = 8;

  // address cycle layout
  localparam int unsigned ADDR_W      = 28;
  localparam logic [1:0]  ACYC_FIRST  = 2'h0;
  localparam logic [1:0]  ACYC_ROW    = 2'h2;
  localparam logic [1:0]  ACYC_LAST   = 2'h3;

  // command codes
  localparam logic [7:0] C_READ      = 8'h00;
  localparam logic [7:0] C_READ_GO   = 8'h30;
  localparam logic [7:0] C_READ_CB   = 8'h35;
  localparam logic [7:0] C_READ_ID   = 8'h90;
  localparam logic [7:0] C_RESET     = 8'hFF;
  localparam logic [7:0] C_PROG      = 8'h80;
  localparam logic [7:0] C_PROG_GO   = 8'h10;
  localparam logic [7:0] C_CPROG_GO  = 8'h15;
  localparam logic [7:0] C_ERASE     = 8'h60;
  localparam logic [7:0] C_ERASE_GO  = 8'hD0;
  localparam logic [7:0] C_STATUS    = 8'h70;
  localparam logic [7:0] C_CACHE_SEQ = 8'h31;
  localparam logic [7:0] C_CACHE_END = 8'h3F;

  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_READ_CB    = 4'h1,
    OP_READ_ID    = 4'h2,
    OP_RESET      = 4'h3,
    OP_PROG       = 4'h4,
    OP_CACHE_PROG = 4'h5,
    OP_ERASE      = 4'h6,
    OP_STATUS     = 4'h7,
    OP_CACHE_SEQ  = 4'h8,
    OP_CACHE_END  = 4'h9,
    OP_CACHE_RAND = 4'hA
  } nbc_op_e;

  // gray along idle, cmd, addr, data, cmd2, wait, read, done
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_CMD1  = 4'h1,
    ST_ADDR  = 4'h3,
    ST_WDATA = 4'h2,
    ST_CMD2  = 4'h6,
    ST_WAITB = 4'h7,
    ST_WAITR = 4'h5,
    ST_RDATA = 4'h4,
    ST_DONE  = 4'hC
  } nbc_state_e;

  typedef enum logic [1:0] {
    PH_SETUP = 2'h0,
    PH_LOW   = 2'h1,
    PH_HIGH  = 2'h3
  } nbc_phase_e;

endpackage : nbc_pkg

/* File: testbench/nbc_host_asserts.sv */
// nbc_host_asserts: pin and request checks on nbc_host
// assumes the nbc_host port list; bound at the foot
`timescale 1ns/100ps
`default_nettype none
module nbc_host_asserts #(
  parameter int unsigned BUS_W      = 8,
  parameter int unsigned LEN_W      = 12,
  parameter int unsigned FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic             mclk_i,
  input wire logic             rst_n_i,
  // request side
  input wire logic             cmd_valid_i,
  input wire logic             cmd_ready_o,
  input wire logic [3:0]       cmd_op_i,
  input wire logic             dev_ready_o,
  input wire logic             rd_valid_o,
  // nand pins
  input wire logic             nand_ce_n_o,
  input wire logic             nand_cle_o,
  input wire logic             nand_ale_o,
  input wire logic             nand_we_n_o,
  input wire logic             read_strobe_n_o,
  input wire logic             nand_wp_n_o,
  input wire logic [BUS_W-1:0] io_bus_o,
  input wire logic             io_bus_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take_status;
    cmd_valid_i && cmd_ready_o && cmd_op_i == 4'h7;
  endsequence
  sequence s_status_code;
    ##[1:4] nand_cle_o && io_bus_oe_o && io_bus_o[7:0] == 8'h70;
  endsequence
  a_write_pins: assert property (
    !nand_we_n_o |-> !nand_ce_n_o && read_strobe_n_o) else $error("write strobe with bad pins");
  a_read_pins: assert property (
    !read_strobe_n_o |-> !nand_ce_n_o && nand_we_n_o && !nand_cle_o && !nand_ale_o)
    else $error("read strobe with bad pins");
  a_read_bus_free: assert property (
    !read_strobe_n_o |-> !io_bus_oe_o) else $error("host drives bus during read");
  a_latch_driven: assert property (
    $rose(nand_we_n_o) |-> $past(io_bus_oe_o) && !$past(nand_ce_n_o)) else $error("latch edge undriven");
  a_latch_excl: assert property (
    !(nand_cle_o && nand_ale_o)) else $error("both latch strobes high");
  a_cmd_low_lines: assert property (
    nand_cle_o && io_bus_oe_o |-> (io_bus_o >> 8) == '0) else $error("command on upper lines");
  a_busy_refuse: assert property (
    cmd_valid_i && !dev_ready_o && cmd_op_i != 4'h3 && cmd_op_i != 4'h7 |-> !cmd_ready_o)
    else $error("request taken while busy");
  a_wp_hold: assert property (
    nand_wp_n_o && !dev_ready_o |=> nand_wp_n_o) else $error("protect dropped while busy");
  a_status_code: assert property (
    s_take_status |-> s_status_code) else $error("status code not sent");
  a_read_word: assert property (
    $fell(read_strobe_n_o) |-> ##[1:12] rd_valid_o) else $error("read strobe gave no word");
endmodule // nbc_host_asserts
bind nbc_host nbc_host_asserts #(.BUS_W(BUS_W), .LEN_W(LEN_W), .FIFO_DEPTH(FIFO_DEPTH)) nbc_host_asserts_i (
  .mclk_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .dev_ready_o, .rd_valid_o, .nand_ce_n_o,
  .nand_cle_o, .nand_ale_o, .nand_we_n_o, .read_strobe_n_o, .nand_wp_n_o, .io_bus_o, .io_bus_oe_o);
`default_nettype wire

/* File: testbench/nbc_dev.sv */
// nbc_dev: behavioural x8 nand device on the far side of nbc_host
// assumes the bench resolves the bus and pulls ready/busy up
`timescale 1ns/100ps
`default_nettype none
module nbc_dev #(
  parameter int BUSY_NS = 400,
  parameter int ACC_NS  = 20
) (
  // pins from host
  input wire logic       ce_n_i,
  input wire logic       cle_i,
  input wire logic       ale_i,
  input wire logic       we_n_i,
  input wire logic       re_n_i,
  input wire logic       wp_n_i,
  input wire logic [7:0] io_i,
  // pins to host
  output logic     [7:0] io_o,
  output logic           rb_low_o
);
  logic [7:0]  mem [int];
  logic [7:0]  cmd_log [$];
  logic [7:0]  addr_log [$];
  logic [27:0] adr;
  logic [7:0]  cmd_q;
  int          acnt;
  int          dq [$];
  event        go;
  initial begin
    io_o = 8'h00;
    rb_low_o = 1'b0;
    cmd_q = 8'h00;
    acnt = 0;
    adr = '0;
  end
  // busy runs on regardless of select
  always begin
    @(go);
    rb_low_o = 1'b1;
    #(BUSY_NS);
    rb_low_o = 1'b0;
  end
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i) begin
      if (!rb_low_o || io_i inside {8'hFF, 8'h70}) begin
        cmd_log.push_back(io_i);
        acnt = (io_i == 8'h60) ? 2 : 0;
        if (io_i inside {8'h30, 8'h35, 8'h31, 8'h3F, 8'hFF}) -> go;
        if (io_i inside {8'h10, 8'h15} && wp_n_i) -> go;
        if (io_i == 8'hD0 && wp_n_i) begin
          dq.delete();
          foreach (mem[k]) if (k[27:18] == adr[27:18]) dq.push_back(k);
          foreach (dq[j]) mem.delete(dq[j]);
          -> go;
        end
        if (io_i inside {8'h00, 8'h70, 8'h80, 8'h60, 8'h90, 8'hFF}) cmd_q = (io_i == 8'hFF) ? 8'h00 : io_i;
      end
    end else if (ale_i) begin
      addr_log.push_back(io_i);
      case (acnt)
        0: adr[7:0] = io_i;
        1: adr[11:8] = io_i[3:0];
        2: adr[19:12] = io_i;
        default: adr[27:20] = io_i;
      endcase
      acnt++;
    end else if (cmd_q == 8'h80 && wp_n_i) begin
      mem[adr] = io_i;
      adr[11:0] = adr[11:0] + 12'h001;
    end
  end
  // word out and column step on fall only
  always @(negedge re_n_i) if (!ce_n_i) begin
    #(ACC_NS);
    io_o = (cmd_q == 8'h70) ? {wp_n_i, ~rb_low_o, 6'h00} : (mem.exists(adr) ? mem[adr] : 8'hFF);
    adr[11:0] = adr[11:0] + 12'h001;
  end
  // released bus shows inverted last value
  always @(posedge re_n_i) begin
    #(ACC_NS);
    io_o = ~io_o;
  end
endmodule // nbc_dev
`default_nettype wire

/* File: testbench/tb_top.sv */
// tb_top: self-checking bench for nbc_host in x8 against nbc_dev
// assumes nbc_pkg, nbc_host, nbc_dev and the checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [27:0] A_PG = 28'hB6D52A0;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, wr_valid_i = 1'b0;
  logic [3:0] cmd_op_i = 4'h0;
  logic [27:0] cmd_addr_i = '0;
  logic [11:0] cmd_len_i = '0;
  logic [7:0] wr_data_i = '0, rd_data_o, io_bus_o, io_bus_i, dev_io;
  logic cmd_ready_o, done_o, busy_o, dev_ready_o, wr_ready_o, rd_valid_o, rb_low;
  logic nand_ce_n_o, nand_cle_o, nand_ale_o, nand_we_n_o, read_strobe_n_o, nand_wp_n_o, io_bus_oe_o;
  logic ready_busy_n_i;
  logic [7:0] rd_q [$];
  int n_errors = 0, samples_checked = 0;
  logic [15:0] ctab [12] = '{16'h0030, 16'h0035, 16'h0090, 16'h00FF, 16'h8010, 16'h8015,
                             16'h60D0, 16'h0070, 16'h0031, 16'h003F, 16'h0031, 16'h0000};
  int cn [12] = '{2, 2, 1, 1, 2, 2, 2, 1, 1, 1, 2, 0};
  always #5 mclk_i = ~mclk_i;
  assign io_bus_i = io_bus_oe_o ? io_bus_o : dev_io;
  assign ready_busy_n_i = ~rb_low;
  always @(negedge mclk_i) if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
  nbc_host #(.BUS_W(8)) nbc_host_i (.mclk_i, .rst_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_addr_i,
    .cmd_len_i, .done_o, .busy_o, .dev_ready_o, .wr_valid_i, .wr_ready_o, .wr_data_i, .rd_valid_o,
    .rd_data_o, .nand_ce_n_o, .nand_cle_o, .nand_ale_o, .nand_we_n_o, .read_strobe_n_o, .nand_wp_n_o,
    .io_bus_o, .io_bus_oe_o, .io_bus_i, .ready_busy_n_i);
  nbc_dev nbc_dev_i (.ce_n_i(nand_ce_n_o), .cle_i(nand_cle_o), .ale_i(nand_ale_o), .we_n_i(nand_we_n_o),
    .re_n_i(read_strobe_n_o), .wp_n_i(nand_wp_n_o), .io_i(io_bus_i), .io_o(dev_io), .rb_low_o(rb_low));
  function automatic logic [7:0] pat(input int i);
    return 8'h1D * i[7:0] + 8'h3C;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_op(input logic [3:0] op, input logic [27:0] a, input logic [11:0] n);
    int w;
    nbc_dev_i.cmd_log.delete();
    nbc_dev_i.addr_log.delete();
    rd_q.delete();
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_len_i <= n;
    cmd_valid_i <= 1'b1;
    w = 0;
    do @(negedge mclk_i); while (cmd_ready_o !== 1'b1 && ++w < 3000);
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    @(negedge mclk_i);
    check(busy_o, 1'b1);
    do @(negedge mclk_i); while (done_o !== 1'b1 && ++w < 6000);
    check(w < 6000, 1'b1);
    check(busy_o, 1'b0);
    @(posedge mclk_i);
  endtask
  task automatic t_codes;
    for (int op = 0; op < 12; op++) begin
      do_op(op[3:0], 28'h0000000, 12'h000);
      check(nbc_dev_i.cmd_log.size(), cn[op]);
      if (cn[op] == 2) check(nbc_dev_i.cmd_log[0], ctab[op][15:8]);
      if (cn[op] > 0) check(nbc_dev_i.cmd_log[cn[op]-1], ctab[op][7:0]);
    end
  endtask
  task automatic t_prog;
    int cnt;
    logic [7:0] ab [4];
    cnt = 0;
    ab = '{A_PG[7:0], {4'h0, A_PG[11:8]}, A_PG[19:12], A_PG[27:20]};
    for (int i = 0; i < 20; i++) begin
      wr_data_i <= pat(i);
      wr_valid_i <= 1'b1;
      @(negedge mclk_i);
      if (wr_ready_o === 1'b1) cnt++;
      @(posedge mclk_i);
    end
    wr_valid_i <= 1'b0;
    check(cnt, 16);
    do_op(4'h4, A_PG, 12'h010);
    do_op(4'h7, A_PG, 12'h001);
    check(rd_q[0], 8'h40);
    do_op(4'h0, A_PG, 12'h010);
    for (int i = 0; i < 4; i++) check(nbc_dev_i.addr_log[i], ab[i]);
    for (int i = 0; i < 16; i++) check(rd_q[i], pat(i));
  endtask
  // device busy refuses reads, takes status
  task automatic t_busy;
    -> nbc_dev_i.go;
    repeat (4) @(posedge mclk_i);
    cmd_op_i <= 4'h0;
    cmd_valid_i <= 1'b1;
    repeat (5) begin
      @(negedge mclk_i);
      check(cmd_ready_o, 1'b0);
      check(dev_ready_o, 1'b0);
    end
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    @(posedge mclk_i);
    do_op(4'h7, A_PG, 12'h001);
    check(rd_q[0], 8'h00);
  endtask
  task automatic t_erase;
    do_op(4'h6, A_PG, 12'h000);
    check(nbc_dev_i.addr_log.size(), 2);
    check(nbc_dev_i.addr_log[0], A_PG[19:12]);
    check(nbc_dev_i.addr_log[1], A_PG[27:20]);
    do_op(4'h0, A_PG, 12'h002);
    check(rd_q.size(), 2);
    check(rd_q[1], 8'hFF);
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_codes();
    t_prog();
    t_busy();
    t_erase();
    results();
  end
  initial begin
    #(400_000);
    n_errors++;
    results();
  end
endmodule // tb_top
`default_nettype wire
